// File: src/rtmsg_core.v
// Mode legality lookup, receive store and interrupt log of a terminal
// How it works
// - Tx mode legality from 0x1FF/0x1C1, 0x1FE/0x1C0
// - Rx mode legality from 0x1BF/0x181, 0x1BE/0x180
// - Broadcast Tx legality from 0x17F/0x141, 0x17E/0x140
// - Broadcast Rx legality from 0x13F/0x101, 0x13E/0x100
// - Bit one: status only, error, no data
// - Temp store 0x20-0x3F used when enabled
// - Enabled: hold words, burst copy on success
// - Disabled: each word written directly on arrival
// - Only enabled types interrupt; two pins, two acks
// - Ring log 0x40-0x5F, sixteen entries, two words
// - Identification word holds only occurring type bits
// - Message type bits 15,14,13,10,8
// - Hardware type bits 7 down to 0
// - Address word: control word address, hardware zero
// - Concurrent message types share one word, one alert
// - Pointer resets 0x40, steps per word, wraps
// - Event count in 15:8, saturating, cleared by read
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rtmsg_defs.vh"

module rtmsg_core (
   input wire mclk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire cmdValid,
   input wire cmdTransmit,
   input wire cmdBroadcast,
   input wire [4:0] cmdSubaddr,
   input wire [4:0] cmdModeCode,
   output reg legalDone,
   output reg cmdIllegal,
   input wire rxWordValid,
   input wire [15:0] rxWord,
   input wire [9:0] rxDataBase,
   input wire msgEnd,
   input wire msgError,
   input wire [4:0] msgIntFlags,
   input wire [15:0] msgCtrlAddr,
   input wire [7:0] hwEvent,
   input wire msgIntAck,
   input wire hwIntAck,
   output reg messageInterruptOutput,
   output reg hwInterruptOutput,
   output wire irq
);
   // Sequencer states
   localparam [3:0] S_CLR = 4'd0;
   localparam [3:0] S_IDLE = 4'd1;
   localparam [3:0] S_LEGW = 4'd2;
   localparam [3:0] S_HRDW = 4'd3;
   localparam [3:0] S_CPYR = 4'd4;
   localparam [3:0] S_CPYW = 4'd5;
   localparam [3:0] S_MSGLOG = 4'd6;
   localparam [3:0] S_LOGI = 4'd7;
   localparam [3:0] S_LOGA = 4'd8;

   // Word address plus small index, kept to RAM width
   function [9:0] addIdx;
      input [9:0] base;
      input [5:0] idx;
      begin
         addIdx = base + {4'h0, idx};
      end
   endfunction

   // Spread message flags into identification word layout
   function [15:0] msgIdWord;
      input [4:0] f;
      begin
         msgIdWord = 16'h0000;
         msgIdWord[`RTMSG_ID_INDEX_EQUAL_ZERO_INT] = f[4];
         msgIdWord[`RTMSG_ID_IWA] = f[3];
         msgIdWord[`RTMSG_ID_IBR] = f[2];
         msgIdWord[`RTMSG_ID_MESSAGE_ERROR_INT] = f[1];
         msgIdWord[`RTMSG_ID_ILLEGAL_COMMAND_INT] = f[0];
      end
   endfunction

   reg [3:0] state; // Sequencer state
   reg [9:0] clrAddr; // RAM clear sweep address
   reg [15:0] cfg2; // Configuration 2, bit 0 enables temp store
   reg [15:0] intEnable; // Per-type enables, id word layout
   reg [3:0] status; // Sticky events
   reg [3:0] mask; // Interrupt mask
   reg [4:0] logPtr; // Ring word offset
   reg [7:0] intCount; // Events since last read
   reg legPend; // Legality fetch waiting
   reg [9:0] legAddr; // Word to fetch
   reg [3:0] legBit; // Bit within that word
   reg rxPend; // Received word waiting
   reg [15:0] rxData; // Its value
   reg [9:0] rxBase; // Assigned subaddress data area
   reg [5:0] rxCnt; // Words so far in this message
   reg [5:0] cpyIdx; // Burst copy index
   reg endPend; // Message end waiting
   reg endErr; // It ended in error
   reg [15:0] endId; // Enabled message types
   reg [15:0] endAddr; // Control word address
   reg [7:0] hwPend; // Enabled hardware events waiting
   reg [15:0] logId; // Identification word to store
   reg [15:0] logAw; // Address word to store
   reg logIsMsg; // Entry came from a message
   reg hPend; // AHB data phase in progress
   reg [13:0] hAddr; // Captured byte address
   reg hWrite; // Captured direction
   wire [15:0] ramQ; // RAM read data
   wire tempEn; // Temp store enabled
   wire hRam; // Host access targets RAM
   wire [7:0] hwNew; // Hardware events passing enables
   reg ramEn;
   reg ramWe;
   reg [9:0] ramAddr;
   reg [15:0] ramWdata;
   reg [15:0] regQ; // Register read value
   reg doLeg;
   reg doRx;
   reg doEnd;
   reg doHw;
   reg doHost;

   assign tempEn = cfg2[`RTMSG_CFG2_TRX];
   assign hRam = hAddr < `RTMSG_RAM_SPAN;
   assign hwNew = hwEvent & intEnable[`RTMSG_ID_HW_MSB:0];
   assign hreadyout = ~hPend;
   assign hresp = 1'b0;
   assign irq = |(status & mask);

   rtmsg_ram uRam (
      .mclk(mclk),
      .en(ramEn),
      .we(ramWe),
      .addr(ramAddr),
      .wdata(ramWdata),
      .rdata(ramQ)
   );

   // Idle-state arbitration: bus-side work ahead of the host
   always @* begin
      doLeg = 1'b0;
      doRx = 1'b0;
      doEnd = 1'b0;
      doHw = 1'b0;
      doHost = 1'b0;
      if (state == S_IDLE) begin
         if (legPend) begin
            doLeg = 1'b1;
         end else if (rxPend) begin
            doRx = 1'b1;
         end else if (endPend) begin
            doEnd = 1'b1;
         end else if (|hwPend) begin
            doHw = 1'b1;
         end else if (hPend && hRam) begin
            doHost = 1'b1;
         end
      end
   end

   // RAM port steering; only one owner per cycle
   always @* begin
      ramEn = 1'b0;
      ramWe = 1'b0;
      ramAddr = 10'h000;
      ramWdata = 16'h0000;
      case (state)
         S_CLR: begin
            ramEn = 1'b1;
            ramWe = 1'b1;
            ramAddr = clrAddr;
         end
         S_IDLE: begin
            if (doLeg) begin
               ramEn = 1'b1;
               ramAddr = legAddr;
            end else if (doRx) begin
               ramEn = 1'b1;
               ramWe = 1'b1;
               ramWdata = rxData;
               if (tempEn) begin
                  ramAddr = addIdx(`RTMSG_TRX_BASE, rxCnt);
               end else begin
                  ramAddr = addIdx(rxBase, rxCnt);
               end
            end else if (doHost) begin
               ramEn = 1'b1;
               ramWe = hWrite;
               ramAddr = hAddr[11:2];
               ramWdata = hwdata[15:0];
            end
         end
         S_CPYR: begin
            ramEn = 1'b1;
            ramAddr = addIdx(`RTMSG_TRX_BASE, cpyIdx);
         end
         S_CPYW: begin
            ramEn = 1'b1;
            ramWe = 1'b1;
            ramAddr = addIdx(rxBase, cpyIdx);
            ramWdata = ramQ;
         end
         S_LOGI: begin
            ramEn = 1'b1;
            ramWe = 1'b1;
            ramAddr = addIdx(`RTMSG_LOG_BASE, {1'b0, logPtr});
            ramWdata = logId;
         end
         S_LOGA: begin
            ramEn = 1'b1;
            ramWe = 1'b1;
            ramAddr = addIdx(`RTMSG_LOG_BASE, {1'b0, logPtr});
            ramWdata = logAw;
         end
         default: ramEn = 1'b0;
      endcase
   end

   // Register read mux; unmapped offsets read zero
   always @* begin
      case (hAddr)
         `RTMSG_REG_CFG2: regQ = cfg2;
         `RTMSG_REG_INTEN: regQ = intEnable;
         `RTMSG_REG_LOGADDR: regQ = {intCount,
            `RTMSG_LOG_PTR_RESET | {3'b000, logPtr}};
         `RTMSG_REG_STATUS: regQ = {12'h000, status};
         `RTMSG_REG_MASK: regQ = {12'h000, mask};
         default: regQ = 16'h0000;
      endcase
   end

   // Sequencer, event capture, bus slave and registers
   always @(posedge mclk) begin
      if (rst) begin
         state <= S_CLR;
         clrAddr <= 10'h000;
         cfg2 <= `RTMSG_CFG2_RESET;
         intEnable <= `RTMSG_INTEN_RESET;
         status <= `RTMSG_STATUS_RESET;
         mask <= `RTMSG_MASK_RESET;
         logPtr <= 5'h00;
         intCount <= 8'h00;
         legPend <= 1'b0;
         legAddr <= 10'h000;
         legBit <= 4'h0;
         rxPend <= 1'b0;
         rxData <= 16'h0000;
         rxBase <= 10'h000;
         rxCnt <= 6'h00;
         cpyIdx <= 6'h00;
         endPend <= 1'b0;
         endErr <= 1'b0;
         endId <= 16'h0000;
         endAddr <= 16'h0000;
         hwPend <= 8'h00;
         logId <= 16'h0000;
         logAw <= 16'h0000;
         logIsMsg <= 1'b0;
         hPend <= 1'b0;
         hAddr <= 14'h0000;
         hWrite <= 1'b0;
         hrdata <= 32'h00000000;
         legalDone <= 1'b0;
         cmdIllegal <= 1'b0;
         messageInterruptOutput <= 1'b0;
         hwInterruptOutput <= 1'b0;
      end else begin
         legalDone <= 1'b0;
         // Pick the quadrant and pair for a mode command
         if (cmdValid && (cmdSubaddr == 5'h00 || cmdSubaddr == 5'h1f)) begin
            legPend <= 1'b1;
            legBit <= cmdModeCode[3:0];
            legAddr <= (cmdBroadcast ?
               (cmdTransmit ? `RTMSG_LEG_BTX : `RTMSG_LEG_BRX)
               : (cmdTransmit ? `RTMSG_LEG_TX : `RTMSG_LEG_RX))
               + (cmdSubaddr[0] ? `RTMSG_LEG_SA31 : 10'h000)
               + {9'h000, cmdModeCode[4]};
         end
         // Words come 20us apart, so one holding word suffices
         if (rxWordValid) begin
            rxPend <= 1'b1;
            rxData <= rxWord;
            rxBase <= rxDataBase;
         end
         // Only enabled message types are kept for the log
         if (msgEnd) begin
            endPend <= 1'b1;
            endErr <= msgError;
            endId <= msgIdWord(msgIntFlags) & intEnable;
            endAddr <= msgCtrlAddr;
         end
         // Acks drop the pins; a new entry in the same cycle wins
         if (msgIntAck) begin
            messageInterruptOutput <= 1'b0;
         end
         if (hwIntAck) begin
            hwInterruptOutput <= 1'b0;
         end
         // Hardware events accumulate until logged
         hwPend <= hwPend | hwNew;
         // Address phase; hreadyout low keeps the master waiting
         if (hsel && htrans[1] && hready && !hPend) begin
            hPend <= 1'b1;
            hAddr <= haddr[13:0];
            hWrite <= hwrite;
         end
         // Register access completes one cycle into the data phase
         if (hPend && !hRam) begin
            hPend <= 1'b0;
            hrdata <= {16'h0000, regQ};
            if (hWrite) begin
               case (hAddr)
                  `RTMSG_REG_CFG2: cfg2 <= hwdata[15:0];
                  `RTMSG_REG_INTEN: intEnable <= hwdata[15:0];
                  `RTMSG_REG_MASK: mask <= hwdata[3:0];
                  default: cfg2 <= cfg2;
               endcase
            end
         end
         case (state)
            // Master reset leaves every shared word zero
            S_CLR: begin
               clrAddr <= clrAddr + 10'h001;
               if (clrAddr == `RTMSG_RAM_LAST) begin
                  state <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (doLeg) begin
                  legPend <= cmdValid;
                  state <= S_LEGW;
               end else if (doRx) begin
                  rxPend <= rxWordValid;
                  rxCnt <= rxCnt + 6'h01;
               end else if (doEnd) begin
                  endPend <= msgEnd;
                  cpyIdx <= 6'h00;
                  // With the temp store on, failed messages leave the data area untouched
                  if (tempEn && !endErr && rxCnt != 6'h00) begin
                     state <= S_CPYR;
                  end else begin
                     state <= S_MSGLOG;
                  end
               end else if (doHw) begin
                  logId <= {8'h00, hwPend};
                  logAw <= 16'h0000;
                  logIsMsg <= 1'b0;
                  hwPend <= hwNew;
                  state <= S_LOGI;
               end else if (doHost) begin
                  if (hWrite) begin
                     hPend <= 1'b0;
                  end else begin
                     state <= S_HRDW;
                  end
               end
            end
            S_LEGW: begin
               legalDone <= 1'b1;
               cmdIllegal <= ramQ[legBit];
               if (ramQ[legBit]) begin
                  status[`RTMSG_ST_ILLEGAL] <= 1'b1;
               end
               state <= S_IDLE;
            end
            S_HRDW: begin
               hrdata <= {16'h0000, ramQ};
               hPend <= 1'b0;
               state <= S_IDLE;
            end
            S_CPYR: begin
               state <= S_CPYW;
            end
            // Burst: one word per read/write pair
            S_CPYW: begin
               cpyIdx <= cpyIdx + 6'h01;
               if (cpyIdx + 6'h01 == rxCnt) begin
                  state <= S_MSGLOG;
               end else begin
                  state <= S_CPYR;
               end
            end
            // All enabled types of one message share one entry
            S_MSGLOG: begin
               rxCnt <= 6'h00;
               logId <= endId;
               logAw <= endAddr;
               logIsMsg <= 1'b1;
               if (|endId) begin
                  state <= S_LOGI;
               end else begin
                  state <= S_IDLE;
               end
            end
            S_LOGI: begin
               logPtr <= logPtr + 5'h01;
               state <= S_LOGA;
            end
            S_LOGA: begin
               logPtr <= logPtr + 5'h01;
               if (logIsMsg) begin
                  messageInterruptOutput <= 1'b1;
                  status[`RTMSG_ST_MSGLOG] <= 1'b1;
               end else begin
                  hwInterruptOutput <= 1'b1;
                  status[`RTMSG_ST_HWLOG] <= 1'b1;
               end
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
         // Reading the log address clears the count; an event wins
         if (state == S_LOGA) begin
            if (hPend && !hRam && !hWrite && hAddr == `RTMSG_REG_LOGADDR) begin
               intCount <= 8'h01;
            end else if (intCount != `RTMSG_CNT_MAX) begin
               intCount <= intCount + 8'h01;
            end
            if (intCount >= `RTMSG_CNT_OVR) begin
               status[`RTMSG_ST_OVERRUN] <= 1'b1;
            end
         end else if (hPend && !hRam && !hWrite
                      && hAddr == `RTMSG_REG_LOGADDR) begin
            intCount <= 8'h00;
         end
         // Write one to clear; bits set this cycle stay set
         if (hPend && !hRam && hWrite && hAddr == `RTMSG_REG_STATUS) begin
            status <= (status & ~hwdata[3:0])
               | {state == S_LOGA && intCount >= `RTMSG_CNT_OVR,
                  state == S_LEGW && ramQ[legBit],
                  state == S_LOGA && !logIsMsg,
                  state == S_LOGA && logIsMsg};
         end
      end
   end
endmodule // rtmsg_core
`default_nettype wire

// File: src/rtmsg_defs.vh
// Constants for the remote-terminal message support block
`ifndef RTMSG_DEFS_VH
`define RTMSG_DEFS_VH

// Shared RAM geometry (16-bit words)
`define RTMSG_RAM_AW 10
`define RTMSG_RAM_WORDS 1024
`define RTMSG_RAM_LAST 10'h3ff

// Temporary receive store, 32 words
`define RTMSG_TRX_BASE 10'h020
`define RTMSG_TRX_LAST 10'h03f

// Interrupt log ring, 16 entries of two words
`define RTMSG_LOG_BASE 10'h040
`define RTMSG_LOG_LAST 10'h05f
`define RTMSG_LOG_PTR_RESET 8'h40

// Mode-command legality quadrants (subaddress 0 pair)
`define RTMSG_LEG_TX 10'h1c0
`define RTMSG_LEG_RX 10'h180
`define RTMSG_LEG_BTX 10'h140
`define RTMSG_LEG_BRX 10'h100
// Added to reach the subaddress 31 pair
`define RTMSG_LEG_SA31 10'h03e

// Identification word bit positions
`define RTMSG_ID_INDEX_EQUAL_ZERO_INT 15
`define RTMSG_ID_IWA 14
`define RTMSG_ID_IBR 13
`define RTMSG_ID_MESSAGE_ERROR_INT 10
`define RTMSG_ID_ILLEGAL_COMMAND_INT 8
`define RTMSG_ID_HW_MSB 7

// Register byte offsets (RAM word n sits at byte 4*n below these)
`define RTMSG_REG_CFG2 14'h1000
`define RTMSG_REG_INTEN 14'h1004
`define RTMSG_REG_LOGADDR 14'h1008
`define RTMSG_REG_STATUS 14'h100c
`define RTMSG_REG_MASK 14'h1010
`define RTMSG_RAM_SPAN 14'h1000

// Configuration 2 field
`define RTMSG_CFG2_TRX 0

// Status / mask bits
`define RTMSG_ST_MSGLOG 0
`define RTMSG_ST_HWLOG 1
`define RTMSG_ST_ILLEGAL 2
`define RTMSG_ST_OVERRUN 3

// Reset values
`define RTMSG_CFG2_RESET 16'h0000
`define RTMSG_INTEN_RESET 16'h0000
`define RTMSG_STATUS_RESET 4'h0
`define RTMSG_MASK_RESET 4'h0

// Interrupt count saturation and overrun threshold
`define RTMSG_CNT_MAX 8'hff
`define RTMSG_CNT_OVR 8'h10

`endif

// File: src/rtmsg_ram.v
// Single-port shared RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "rtmsg_defs.vh"

module rtmsg_ram (
   input wire mclk,
   input wire en,
   input wire we,
   input wire [`RTMSG_RAM_AW-1:0] addr,
   input wire [15:0] wdata,
   output reg [15:0] rdata
);
   // Storage array; cleared by the owner's sweep after reset
   reg [15:0] mem [0:`RTMSG_RAM_WORDS-1];

   // One access per cycle; read data valid the cycle after
   always @(posedge mclk) begin
      if (en) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata <= mem[addr];
      end
   end
endmodule // rtmsg_ram
`default_nettype wire

// File: sim/rtmsg_core_asserts.sv
// Port-level concurrent checks for the message support core
`timescale 1ns/1ps
`default_nettype none

module rtmsg_core_asserts (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmdValid,
   input wire logic [4:0] cmdSubaddr,
   input wire logic legalDone,
   input wire logic cmdIllegal,
   input wire logic msgEnd,
   input wire logic [7:0] hwEvent,
   input wire logic msgIntAck,
   input wire logic hwIntAck,
   input wire logic messageInterruptOutput,
   input wire logic hwInterruptOutput
);
   // Saturating ages of the last causes
   logic [7:0] sinceMsg;
   logic [7:0] sinceHw;

   // Age counters let a pin rise be tied to a recent cause
   always @(posedge mclk) begin
      if (rst) begin
         sinceMsg <= 8'hff;
         sinceHw <= 8'hff;
      end else begin
         sinceMsg <= msgEnd ? 8'h00 : sinceMsg + {7'h0, sinceMsg != 8'hff};
         sinceHw <= (|hwEvent) ? 8'h00 : sinceHw + {7'h0, sinceHw != 8'hff};
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_mode_answer;
      cmdValid && (cmdSubaddr == 5'h00 || cmdSubaddr == 5'h1f)
         |-> ##[2:100] legalDone;
   endproperty
   a_mode_answer: assert property (p_mode_answer)
      else $error("mode command got no lookup result");
   property p_done_pulse;
      legalDone |=> !legalDone;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("lookup result pulse too long");
   property p_illegal_hold;
      $changed(cmdIllegal) |-> legalDone;
   endproperty
   a_illegal_hold: assert property (p_illegal_hold)
      else $error("illegal flag moved alone");
   property p_msg_cause;
      $rose(messageInterruptOutput) |-> sinceMsg <= 8'd100;
   endproperty
   a_msg_cause: assert property (p_msg_cause)
      else $error("message pin rose without a message end");
   property p_msg_hold;
      messageInterruptOutput && !msgIntAck |=> messageInterruptOutput;
   endproperty
   a_msg_hold: assert property (p_msg_hold)
      else $error("message pin dropped early");
   property p_msg_ack;
      msgIntAck && messageInterruptOutput |=> !messageInterruptOutput;
   endproperty
   a_msg_ack: assert property (p_msg_ack)
      else $error("message pin ignored acknowledge");
   property p_hw_cause;
      $rose(hwInterruptOutput) |-> sinceHw <= 8'd100;
   endproperty
   a_hw_cause: assert property (p_hw_cause)
      else $error("hardware pin rose without an event");
   property p_hw_hold;
      hwInterruptOutput && !hwIntAck |=> hwInterruptOutput;
   endproperty
   a_hw_hold: assert property (p_hw_hold)
      else $error("hardware pin dropped early");
   property p_hw_ack;
      hwIntAck && hwInterruptOutput |=> !hwInterruptOutput;
   endproperty
   a_hw_ack: assert property (p_hw_ack)
      else $error("hardware pin ignored acknowledge");
endmodule // rtmsg_core_asserts

`default_nettype wire

// File: sim/rtmsg_host_model.sv
// Host model that answers both interrupt pins with acknowledges
`timescale 1ns/1ps
`default_nettype none

module rtmsg_host_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic messageInterruptOutput,
   input wire logic hwInterruptOutput,
   input wire logic [7:0] lag,
   output logic msgIntAck,
   output logic hwIntAck
);
   // Cycles each pin has waited for service
   logic [7:0] msgWait;
   logic [7:0] hwWait;

   // Ack after lag cycles, one cycle wide
   // Never writes the temporary store
   always @(posedge mclk) begin
      if (rst) begin
         msgWait <= 8'h00;
         hwWait <= 8'h00;
         msgIntAck <= 1'b0;
         hwIntAck <= 1'b0;
      end else begin
         msgWait <= (messageInterruptOutput && !msgIntAck)
            ? msgWait + 8'h01 : 8'h00;
         msgIntAck <= messageInterruptOutput && !msgIntAck && msgWait >= lag;
         hwWait <= (hwInterruptOutput && !hwIntAck) ? hwWait + 8'h01 : 8'h00;
         hwIntAck <= hwInterruptOutput && !hwIntAck && hwWait >= lag;
      end
   end
endmodule // rtmsg_host_model

`default_nettype wire

// File: sim/rtmsg_core_bench.sv
// Self-checking bench for the message support core
`timescale 1ns/1ps
`default_nettype none
`include "rtmsg_defs.vh"

module rtmsg_core_bench;
   localparam int cfgAddr = `RTMSG_REG_CFG2;
   localparam int enAddr = `RTMSG_REG_INTEN;
   localparam int logAddr = `RTMSG_REG_LOGADDR;
   localparam int stAddr = `RTMSG_REG_STATUS;
   localparam int maskAddr = `RTMSG_REG_MASK;
   // Design inputs
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic cmdValid = 1'b0;
   logic cmdTransmit = 1'b0;
   logic cmdBroadcast = 1'b0;
   logic [4:0] cmdSubaddr = 5'h0;
   logic [4:0] cmdModeCode = 5'h0;
   logic rxWordValid = 1'b0;
   logic [15:0] rxWord = 16'h0;
   logic [9:0] rxDataBase = 10'h0;
   logic msgEnd = 1'b0;
   logic msgError = 1'b0;
   logic [4:0] msgIntFlags = 5'h0;
   logic [15:0] msgCtrlAddr = 16'h0;
   logic [7:0] hwEvent = 8'h0;
   logic [7:0] lag = 8'h0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, legalDone, cmdIllegal, irq, msgIntAck, hwIntAck;
   wire messageInterruptOutput, hwInterruptOutput;
   int mismatches = 0;
   int cmpCount = 0;

   // 25 MHz clock
   always #20 mclk = ~mclk;

   rtmsg_core uut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .cmdValid, .cmdTransmit, .cmdBroadcast, .cmdSubaddr, .cmdModeCode,
      .legalDone, .cmdIllegal, .rxWordValid, .rxWord, .rxDataBase, .msgEnd,
      .msgError, .msgIntFlags, .msgCtrlAddr, .hwEvent, .msgIntAck, .hwIntAck,
      .messageInterruptOutput, .hwInterruptOutput, .irq);
   rtmsg_host_model host (.mclk, .rst, .messageInterruptOutput,
      .hwInterruptOutput, .lag, .msgIntAck, .hwIntAck);

   // Verdict, shared with the watchdog
   task close_out;
      if (mismatches == 0 && cmpCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmpCount++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   // Wait for hready high, bounded; a stall counts as a mismatch
   task waitRdy;
      int n;
      n = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk({14'h0, hresp, hreadyout}, 16'h1);
   endtask

   // Single word: address phase, then data phase
   task bus(input logic wr, input logic [31:0] a,
      input logic [15:0] d, output logic [15:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {16'h0, d};
      waitRdy();
      q = hrdata[15:0];
   endtask

   task wr(input logic [31:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rdc(input logic [31:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0, q);
      chk(q, e);
   endtask

   // RAM word to byte address
   function logic [31:0] m(input int w);
      return 32'(w * 4);
   endfunction

   // Mode command to quadrant q; check pulse and flag
   task cmd(input int q, input logic [4:0] sa, input logic [4:0] mc,
      input logic e);
      int n;
      n = 0;
      cmdTransmit <= !q[0];
      cmdBroadcast <= q[1];
      cmdSubaddr <= sa;
      cmdModeCode <= mc;
      cmdValid <= 1'b1;
      @(posedge mclk);
      cmdValid <= 1'b0;
      while (legalDone !== 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      chk({14'h0, legalDone, cmdIllegal}, {14'h0, 1'b1, e});
   endtask

   // Received word, words spaced apart
   task rx(input logic [15:0] w);
      rxWord <= w;
      rxWordValid <= 1'b1;
      @(posedge mclk);
      rxWordValid <= 1'b0;
      repeat (12) @(posedge mclk);
   endtask

   task fin(input logic e, input logic [4:0] f,
      input logic [15:0] ca);
      msgError <= e;
      msgIntFlags <= f;
      msgCtrlAddr <= ca;
      msgEnd <= 1'b1;
      @(posedge mclk);
      msgEnd <= 1'b0;
      repeat (40) @(posedge mclk);
   endtask

   task hw(input logic [7:0] v);
      hwEvent <= v;
      @(posedge mclk);
      hwEvent <= 8'h0;
      repeat (12) @(posedge mclk);
   endtask

   // Watchdog: the whole run needs well under 20k cycles
   initial begin
      #(40 * 60000);
      mismatches++;
      close_out();
   end

   // Main sequence
   initial begin
      int qb[4];
      qb = '{'h1c0, 'h180, 'h140, 'h100};
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rdc(cfgAddr, 16'h0);
      rdc(enAddr, 16'h0);
      rdc(logAddr, 16'h0040);
      // Each quadrant gets shifted patterns so a wrong quadrant shows
      for (int q = 0; q < 4; q++) begin
         wr(m(qb[q]), 16'h0001 << q);
         wr(m(qb[q] + 1), 16'h8000 >> q);
         wr(m(qb[q] + 'h3e), 16'h0010 << q);
         wr(m(qb[q] + 'h3f), 16'h0);
      end
      for (int q = 0; q < 4; q++) begin
         cmd(q, 5'd0, 5'(q), 1'b1);
         cmd(q, 5'd0, 5'(q + 1), 1'b0);
         cmd(q, 5'd0, 5'(31 - q), 1'b1);
         cmd(q, 5'd31, 5'(q), 1'b0);
         cmd(q, 5'd31, 5'(q + 4), 1'b1);
      end
      // Store off: words land directly, even from a failed message
      rxDataBase <= 10'h300;
      rx(16'h1111);
      rx(16'h2222);
      fin(1'b1, 5'h0, 16'h0);
      rdc(m('h300), 16'h1111);
      rdc(m('h301), 16'h2222);
      rdc(m('h20), 16'h0);
      // Store on: a failed message leaves the data area alone
      wr(cfgAddr, 16'h0001);
      rx(16'haaaa);
      rx(16'hbbbb);
      fin(1'b1, 5'h0, 16'h0);
      rdc(m('h300), 16'h1111);
      rdc(m('h20), 16'haaaa);
      rdc(m('h21), 16'hbbbb);
      rxDataBase <= 10'h310;
      rx(16'h3333);
      rx(16'h4444);
      rx(16'h5555);
      fin(1'b0, 5'h0, 16'h0);
      rdc(m('h310), 16'h3333);
      rdc(m('h311), 16'h4444);
      rdc(m('h312), 16'h5555);
      // Interrupt log; the access type stays disabled
      wr(enAddr, 16'ha590);
      wr(maskAddr, 16'h0003);
      wr(stAddr, 16'h000f);
      lag <= 8'd200;
      fin(1'b0, 5'b11110, 16'h0278);
      chk({15'h0, messageInterruptOutput}, 16'h1);
      chk({15'h0, irq}, 16'h1);
      rdc(m('h40), 16'ha400);
      rdc(m('h41), 16'h0278);
      rdc(stAddr, 16'h0001);
      repeat (220) @(posedge mclk);
      chk({15'h0, messageInterruptOutput}, 16'h0);
      wr(stAddr, 16'h0001);
      chk({15'h0, irq}, 16'h0);
      lag <= 8'd0;
      fin(1'b0, 5'b00001, 16'h0300);
      rdc(m('h42), 16'h0100);
      hw(8'h50);
      hw(8'h80);
      hw(8'h01);
      rdc(m('h44), 16'h0010);
      rdc(m('h45), 16'h0000);
      rdc(m('h46), 16'h0080);
      rdc(logAddr, 16'h0448);
      rdc(logAddr, 16'h0048);
      repeat (14) hw(8'h10);
      rdc(m('h5e), 16'h0010);
      rdc(m('h40), 16'h0010);
      rdc(logAddr, 16'h0e44);
      wr(stAddr, 16'h000f);
      repeat (17) hw(8'h10);
      rdc(logAddr, 16'h1146);
      rdc(stAddr, 16'h000a);
      repeat (256) hw(8'h10);
      rdc(logAddr, 16'hff46);
      wr(maskAddr, 16'h0);
      chk({15'h0, irq}, 16'h0);
      close_out();
   end
endmodule // rtmsg_core_bench

bind rtmsg_core rtmsg_core_asserts chk_i (.mclk, .rst, .cmdValid, .cmdSubaddr,
   .legalDone, .cmdIllegal, .msgEnd, .hwEvent, .msgIntAck, .hwIntAck,
   .messageInterruptOutput, .hwInterruptOutput);

`default_nettype wire
